// [rtl/plad_defines.svh]
// Constants for the pointer literal add execution unit.
// Assumes inclusion by bare name from rtl/ files.
`ifndef PLAD_DEFINES_SVH
`define PLAD_DEFINES_SVH

`define PLAD_PTR_W      12
`define PLAD_PC_W       21
`define PLAD_LIT_W      6
`define PLAD_SEL_W      2
`define PLAD_OPC_HI     8'hE8
`define PLAD_OPC_B7     7
`define PLAD_OPC_B6     6
`define PLAD_SEL_RET    2'h3
`define PLAD_SEL_PTR2   2'h2
`define PLAD_PTR_RST    12'h000
`define PLAD_PC_RST     21'h000000

`endif

// [rtl/plad_pkg.sv]
// Types for the pointer literal add execution unit.
// Assumes nothing beyond plad_defines.svh.
`include "plad_defines.svh"

package plad_pkg;

  typedef enum logic [1:0] {
    PLAD_IDLE = 2'b00,
    PLAD_NOP  = 2'b01
  } plad_state_e;

  typedef logic [`PLAD_PTR_W-1:0] plad_ptr_t;

endpackage

// [rtl/plad_adder.sv]
// Pointer plus zero-extended literal adder.
// Assumes a combinational use inside plad_exec.
`timescale 1ns/1ps
`include "plad_defines.svh"

module plad_adder #(
  parameter int PTR_W = `PLAD_PTR_W,
  parameter int LIT_W = `PLAD_LIT_W
) (
  input  wire logic [PTR_W-1:0] ptr,
  input  wire logic [LIT_W-1:0] lit,
  output logic      [PTR_W-1:0] sum
);

  // Unsigned literal, wraps at pointer width
  assign sum = ptr + {{(PTR_W-LIT_W){1'b0}}, lit}; // RULE_01

endmodule

// [rtl/plad_exec.sv]
// Execution unit for the pointer literal add and add-and-return instructions.
// Assumes one instruction word per clock when instr_valid is high and core stalls while busy.
`timescale 1ns/1ps
`include "plad_defines.svh"

// Functional notes
// RULE_01 - Add 6-bit literal to selected pointer
// RULE_02 - Selector 3 means add-and-return on pointer two
// RULE_03 - Return form first updates pointer two
// RULE_04 - Then program counter loads from stack top; the code loads it on the same edge that writes pointer two
// RULE_05 - Return form two cycles, plain form one
// RULE_06 - No status flags are ever changed
module plad_exec #(
  parameter int PTR_W = `PLAD_PTR_W,
  parameter int PC_W  = `PLAD_PC_W
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            instr_valid,
  input  wire logic [15:0]     instr_word,
  input  wire logic [PC_W-1:0] return_stack_top,
  output logic [PTR_W-1:0]     indirect_address_pointer_zero,
  output logic [PTR_W-1:0]     indirect_address_pointer_one,
  output logic [PTR_W-1:0]     indirect_address_pointer_two,
  output logic [PC_W-1:0]      pc_load_value,
  output logic                 pc_load,
  output logic                 stack_pop,
  output logic                 busy,
  output logic                 status_write
);

  // ==========================================================
  // State
  typedef struct packed {
    plad_pkg::plad_state_e state;
    logic [2:0][PTR_W-1:0] ptr;
    logic [PC_W-1:0]       pc_val;
    logic                  pc_ld;
    logic                  pop;
    logic                  busy;
  } plad_regs_s;

  plad_regs_s cur_ff;
  plad_regs_s nxt_cur;

  // ==========================================================
  // Decode
  logic                    is_add;
  logic [`PLAD_SEL_W-1:0]  sel;
  logic [`PLAD_LIT_W-1:0]  lit;
  logic [PTR_W-1:0]        add_in;
  logic [PTR_W-1:0]        add_out;

  assign is_add = instr_valid && (instr_word[15:8] == `PLAD_OPC_HI)
                  && (cur_ff.state == plad_pkg::PLAD_IDLE);
  assign sel    = instr_word[`PLAD_OPC_B7:`PLAD_OPC_B6];
  assign lit    = instr_word[`PLAD_LIT_W-1:0];
  // Selector 3 routes to pointer two
  assign add_in = (sel == `PLAD_SEL_RET) ? cur_ff.ptr[2] : cur_ff.ptr[sel]; // RULE_02

  plad_adder #(
    .PTR_W (PTR_W),
    .LIT_W (`PLAD_LIT_W)
  ) u_adder (
    .ptr (add_in),
    .lit (lit),
    .sum (add_out)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.pc_ld = 1'b0;
    nxt_cur.pop   = 1'b0;
    unique case (cur_ff.state)
      plad_pkg::PLAD_IDLE: begin
        nxt_cur.busy = 1'b0;
        if (is_add) begin
          if (sel == `PLAD_SEL_RET) begin
            nxt_cur.ptr[2] = add_out; // RULE_03
            nxt_cur.pc_val = return_stack_top; // RULE_04
            nxt_cur.pc_ld  = 1'b1;
            nxt_cur.pop    = 1'b1;
            nxt_cur.busy   = 1'b1; // RULE_05
            nxt_cur.state  = plad_pkg::PLAD_NOP;
          end else begin
            nxt_cur.ptr[sel] = add_out; // RULE_01
          end
        end
      end
      plad_pkg::PLAD_NOP: begin
        // Second cycle is a dead slot
        nxt_cur.busy  = 1'b0; // RULE_05
        nxt_cur.state = plad_pkg::PLAD_IDLE;
      end
      default: begin
        nxt_cur.busy  = 1'b0;
        nxt_cur.state = plad_pkg::PLAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cur_ff.state  <= plad_pkg::PLAD_IDLE;
      cur_ff.ptr    <= '0;
      cur_ff.pc_val <= `PLAD_PC_RST;
      cur_ff.pc_ld  <= 1'b0;
      cur_ff.pop    <= 1'b0;
      cur_ff.busy   <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================
  // Outputs
  assign indirect_address_pointer_zero = cur_ff.ptr[0];
  assign indirect_address_pointer_one  = cur_ff.ptr[1];
  assign indirect_address_pointer_two  = cur_ff.ptr[2];
  assign pc_load_value                 = cur_ff.pc_val;
  assign pc_load                       = cur_ff.pc_ld;
  assign stack_pop                     = cur_ff.pop;
  assign busy                          = cur_ff.busy;
  // Flags never written by these instructions
  assign status_write                  = 1'b0; // RULE_06

endmodule

// [sim/plad_monitor.sv]
// Port checker for plad_exec.
// Bound onto every plad_exec instance.
`timescale 1ns/1ps
module plad_mon #(parameter int PTR_W = 12) (
  input logic clock,
  input logic reset,
  input logic instr_valid,
  input logic [15:0] instr_word,
  input logic [PTR_W-1:0] indirect_address_pointer_two,
  input logic pc_load,
  input logic stack_pop,
  input logic busy,
  input logic status_write
);
  wire take = instr_valid && instr_word[15:8] == 8'hE8 && !busy;
  wire ret = take && instr_word[7:6] == 2'h3;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_ptr2_sum: assert property (take && instr_word[7] |=>
    indirect_address_pointer_two == $past(indirect_address_pointer_two) + $past(instr_word[5:0]))
    else $error("sum");
  a_ret_pulse: assert property (ret |=> pc_load && stack_pop && busy) else $error("ret");
  a_plain_quiet: assert property (take && !ret |=> !pc_load && !busy) else $error("plain");
  a_busy_once: assert property (busy |=> !busy && $stable(indirect_address_pointer_two)) else $error("busy");
  a_pop_pair: assert property (pc_load == stack_pop) else $error("pop");
  a_no_flags: assert property (!status_write) else $error("flag");
  cover property (ret);
  cover property (busy && instr_valid);
  cover property (take && !ret);
endmodule
bind plad_exec plad_mon #(.PTR_W(PTR_W)) mon (.*);

// [sim/testbench.sv]
// Directed bench for plad_exec.
// Needs rtl/ and the checker compiled first.
`timescale 1ns/1ps
module testbench;
  logic clock = 0, reset = 1, instr_valid = 0, pc_load, stack_pop, busy, status_write;
  logic [15:0] instr_word = 16'h0000;
  logic [20:0] return_stack_top = 21'h000000, pc_load_value;
  logic [11:0] indirect_address_pointer_zero, indirect_address_pointer_one, indirect_address_pointer_two;
  wire [35:0] ptrs = {indirect_address_pointer_zero, indirect_address_pointer_one, indirect_address_pointer_two};
  int miscompares = 0, tests_run = 0;
  plad_exec uut (.*);
  initial forever #25 clock = ~clock;
  task automatic cmp(input logic [59:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %h", $time, got);
    end
  endtask
  task automatic issue(input logic v, input logic [15:0] w);
    @(posedge clock) #5;
    instr_valid = v;
    instr_word = w;
  endtask
  // Foreign opcode first: it must not land on pointer zero
  task automatic plain_adds;
    issue(1, 16'hE93F);
    issue(1, 16'hE83F);
    issue(1, 16'hE87F);
    issue(1, 16'hE8BF);
    issue(0, 16'h0000);
    cmp(ptrs, 36'h03F03F03F);
  endtask
  // Word given during the busy cycle must be dropped
  task automatic add_return;
    return_stack_top = 21'h1ABCD;
    issue(1, 16'hE8E3);
    issue(1, 16'hE801);
    cmp({ptrs, pc_load_value, pc_load, stack_pop, busy}, {36'h03F03F062, 21'h1ABCD, 3'h7});
    issue(0, 16'h0000);
    cmp({ptrs, pc_load, busy, status_write}, {36'h03F03F062, 3'h0});
  endtask
  // Pointer one climbs 63 at a time to the top, then wraps mod 4096
  task automatic wrap_adds;
    repeat (64) issue(1, 16'hE87F);
    issue(1, 16'hE800);
    issue(0, 16'h0000);
    cmp(ptrs, 36'h03FFFF062);
    issue(1, 16'hE841);
    issue(0, 16'h0000);
    cmp(ptrs, 36'h03F000062);
  endtask
  // Reset in mid-run drops a return taken on the same edge
  task automatic reset_mid;
    issue(1, 16'hE8C1);
    reset = 1;
    issue(0, 16'h0000);
    cmp({ptrs, pc_load_value, pc_load, stack_pop, busy}, 60'h0);
    reset = 0;
  endtask
  task automatic complete_run;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #5 reset = 0;
    plain_adds;
    add_return;
    wrap_adds;
    reset_mid;
    complete_run;
  end
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
endmodule
